// *** bench/spc_assertions.sv ***
`timescale 1ns/1ps
module spc_assertions (
    // Watched ports
    input wire logic mclk,
    input wire logic rst,
    input wire logic key_power,
    input wire logic bar_lost,
    input wire logic reg_rd,
    input wire logic disp_on,
    input wire logic disp_dot,
    input wire logic motor_run,
    input wire logic [11:0] motor_setpoint,
    input wire logic [7:0] motor_power_w,
    input wire logic [15:0] reg_rdata
);
    // ****************
    // Port checks
    // ****************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_lost; bar_lost && disp_dot; endsequence
    sequence s_wake; !disp_on && $rose(key_power); endsequence
    a_bar_stop: assert property (s_lost |-> ##[1:3] !motor_run)
        else $error("Motor kept running after bar loss.");
    a_halt_hold: assert property ($fell(motor_run) && disp_on |=>
        !motor_run [*8])
        else $error("Halt after bar loss too short.");
    a_power_wake: assert property (s_wake |-> ##[1:4] disp_on)
        else $error("Power press did not switch on.");
    a_off_quiet: assert property (!disp_on |-> !motor_run && !disp_dot)
        else $error("Motor or dot active while dark.");
    a_dot_ramp: assert property (disp_dot |-> disp_on && motor_run)
        else $error("Dot lit without a running motor.");
    a_spin_zero: assert property ($rose(motor_run) |->
        motor_setpoint <= 12'h00a)
        else $error("Ramp did not start from standstill.");
    a_spd_max: assert property (motor_setpoint <= 12'h7d0)
        else $error("Setpoint above top speed.");
    a_power_lvl: assert property (disp_on |->
        motor_power_w inside {8'h05, 8'h0a, 8'h0f, 8'h14})
        else $error("Drive power off its four levels.");
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("Read data outside its cycle.");
endmodule
bind spc_top spc_assertions chk_i (.*);

// *** bench/spc_partner.sv ***
`timescale 1ns/1ps
module spc_partner
    import spc_pkg::*;
(
    // Motor drive and store
    input wire logic mclk,
    input wire logic drop,
    input wire logic disp_dot,
    input wire logic nv_save,
    input wire logic [NV_W-1:0] nv_data_out,
    output logic bar_lost,
    output logic nv_valid,
    output logic [NV_W-1:0] nv_data_in
);
    // ****************
    // Bar sense and retained word
    // ****************
    initial begin
        nv_valid = 1'b0;
        nv_data_in = '0;
    end
    assign bar_lost = drop && disp_dot;
    always @(posedge mclk) begin
        if (nv_save) begin
            nv_data_in <= nv_data_out;
            nv_valid <= 1'b1;
        end
    end
endmodule

// *** bench/tb_stirrer_panel_speed_control.sv ***
`timescale 1ns/1ps
module tb_stirrer_panel_speed_control;
    import spc_pkg::*;
    logic mclk, rst, bar_lost, nv_valid, nv_save, drop, reg_wr, reg_rd;
    logic disp_on, disp_dot, motor_run;
    logic [3:0] keys;
    logic [1:0] disp_letter;
    logic [11:0] disp_value, motor_setpoint;
    logic [7:0] motor_power_w;
    logic [NV_W-1:0] nv_data_in, nv_data_out;
    logic [2:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    int error_cnt = 0;
    int compares = 0;
    int n;
    logic [15:0] rows [20] = '{16'h8168, 16'h415e, 16'h100a, 16'h900f,
        16'h9014, 16'h9014, 16'h2000, 16'ha006, 16'ha008, 16'h6006,
        16'h6000, 16'h6000, 16'h301e, 16'h7014, 16'h7014, 16'hb01e,
        16'hb03c, 16'hb078, 16'hb078, 16'h015e};
    spc_top #(.TICK_CYCLES_P(5)) uut (.*, .key_mode(keys[0]),
        .key_minus(keys[1]), .key_plus(keys[2]), .key_power(keys[3]));
    spc_partner model (.*);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // ****************
    // Tasks
    // ****************
    task print_verdict;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            error_cnt++;
        end
    endtask
    task press(input int k);
        keys[k] <= 1'b1;
        repeat (100) @(posedge mclk);
        keys[k] <= 1'b0;
        repeat (100) @(posedge mclk);
    endtask
    task quick(input int k);
        keys[k] <= 1'b1;
        repeat (100) @(posedge mclk);
        press(3);
        press(3);
        keys[k] <= 1'b0;
        repeat (20) @(posedge mclk);
    endtask
    task rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task wait_run(input logic v);
        for (n = 0; n < 3000 && motor_run !== v; n++) @(posedge mclk);
        if (n == 3000) begin
            error_cnt++;
            print_verdict;
        end
    endtask
    task do_reset;
        rst <= 1'b1;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    // ****************
    // Sequence
    // ****************
    initial begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        print_verdict;
    end
    initial begin
        rst = 1'b1;
        keys = 4'h0;
        drop = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        do_reset;
        chk(disp_on, 1'b0);
        press(3);
        chk({disp_on, disp_dot, disp_letter, disp_value},
            {2'h3, 2'h0, SPEED_RST});
        foreach (rows[i]) begin
            press(int'(rows[i][15:14]));
            chk({disp_letter, disp_value},
                rows[i][13:0]);
        end
        press(0);
        for (n = 0; n < 30000 && disp_letter !== 2'h0; n++) @(posedge mclk);
        chk(n > 24000 && n < 25500, 1'b1);
        keys[1] <= 1'b1;
        repeat (4000) @(posedge mclk);
        keys[1] <= 1'b0;
        repeat (20) @(posedge mclk);
        chk(disp_value, 12'h140);
        quick(1);
        chk({disp_on, disp_value}, {1'b1, SPEED_MIN});
        quick(2);
        chk({disp_on, disp_dot, disp_value}, {2'h2, SPEED_MAX});
        press(3);
        press(3);
        chk(disp_dot, 1'b1);
        drop <= 1'b1;
        wait_run(1'b0);
        drop <= 1'b0;
        rd(REG_SPEED, {4'h0, SPEED_MAX - SPEED_DROP});
        wait_run(1'b1);
        chk(disp_dot, 1'b1);
        wr(REG_SPEED, 16'h0005);
        rd(REG_SPEED, 16'h0046);
        rd(3'h5, 16'h0000);
        press(3);
        chk({disp_on, motor_run}, 2'h0);
        do_reset;
        rd(REG_SETTINGS, 16'h000f);
        rd(REG_SPEED, 16'h0046);
        chk(disp_on, 1'b0);
        print_verdict;
    end
endmodule

// *** design/spc_key.sv ***
`timescale 1ns/1ps
module spc_key
    import spc_pkg::*;
#(
    parameter bit REPEAT = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic tick_ms,
    // Key level
    input wire logic key,
    // Key events
    output logic press,
    output logic step,
    output logic held
);

    logic key_d_r;
    logic [9:0] cnt_r;
    logic [9:0] period_r;
    logic fire;

    assign held = key_d_r;
    assign fire = REPEAT && key_d_r && tick_ms && cnt_r == 10'h001;

    always_ff @(posedge mclk) begin
        if (rst) begin
            key_d_r <= 1'b0;
            press <= 1'b0;
            step <= 1'b0;
        end else begin
            key_d_r <= key;
            press <= key & ~key_d_r;
            step <= (key & ~key_d_r) | fire;
        end
    end

    // Repeat gap shrinks with every repeat, down to REP_FAST_MS, while the key stays down.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r <= 10'h000;
            period_r <= REP_START_MS;
        end else if (key & ~key_d_r) begin
            cnt_r <= REP_DELAY_MS;
            period_r <= REP_START_MS;
        end else if (fire) begin
            cnt_r <= period_r;
            if (period_r > REP_FAST_MS + REP_DEC_MS) begin
                period_r <= period_r - REP_DEC_MS;
            end else begin
                period_r <= REP_FAST_MS;
            end
        end else if (key_d_r && tick_ms && cnt_r != 10'h000) begin
            cnt_r <= cnt_r - 10'h001;
        end
    end

endmodule

// *** design/spc_pkg.sv ***
package spc_pkg;

    // ************************************************************
    // Clock and time base
    // ************************************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [9:0] MS_PER_S = 10'h3e8;

    // ************************************************************
    // Setting limits and reset values
    // ************************************************************
    localparam logic [11:0] SPEED_MIN = 12'h046;
    localparam logic [11:0] SPEED_MAX = 12'h7d0;
    localparam logic [11:0] SPEED_STEP = 12'h00a;
    localparam logic [11:0] SPEED_DROP = 12'h064;
    localparam logic [11:0] SPEED_RST = 12'h15e;
    localparam logic [7:0] INTV_MAX = 8'hf0;
    localparam logic [7:0] INTV_MIN_ON = 8'h06;
    localparam logic [7:0] INTV_STEP = 8'h02;
    localparam logic [7:0] INTV_RST = 8'h00;
    localparam logic [1:0] POWER_RST = 2'h1;
    localparam logic [1:0] ACCEL_RST = 2'h1;

    // ************************************************************
    // Timing in milliseconds
    // ************************************************************
    localparam logic [12:0] DISP_TIMEOUT_MS = 13'h1388;
    localparam logic [12:0] HALT_MS = 13'h01f4;
    localparam logic [12:0] QS_WINDOW_MS = 13'h03e8;
    localparam logic [9:0] REP_DELAY_MS = 10'h1f4;
    localparam logic [9:0] REP_START_MS = 10'h0c8;
    localparam logic [9:0] REP_FAST_MS = 10'h028;
    localparam logic [9:0] REP_DEC_MS = 10'h014;

    // ************************************************************
    // Register offsets and fields
    // ************************************************************
    localparam logic [2:0] REG_STATUS = 3'h0;
    localparam logic [2:0] REG_SPEED = 3'h1;
    localparam logic [2:0] REG_RAMP = 3'h2;
    localparam logic [2:0] REG_SETTINGS = 3'h3;
    localparam int ST_RUN_BIT = 0;
    localparam int ST_RAMP_BIT = 1;
    localparam int ST_VIEW_LSB = 2;
    localparam int ST_RETRY_LSB = 8;
    localparam int SET_POWER_LSB = 0;
    localparam int SET_ACCEL_LSB = 2;
    localparam int SET_INTV_LSB = 8;

    // ************************************************************
    // Retained setting word layout
    // ************************************************************
    localparam int NV_W = 25;
    localparam int NV_SPEED_LSB = 0;
    localparam int NV_POWER_LSB = 12;
    localparam int NV_ACCEL_LSB = 14;
    localparam int NV_INTV_LSB = 16;
    localparam int NV_RUN_BIT = 24;

    typedef enum logic [1:0] {
        ST_OFF, ST_HALT, ST_RAMP, ST_RUN
    } spc_state_type;

    typedef enum logic [1:0] {
        V_SPEED, V_POWER, V_INTERVAL, V_ACCEL
    } spc_view_type;

    function automatic logic [7:0] accel_sec(input logic [1:0] idx);
        unique case (idx)
            2'h0: accel_sec = 8'h14;
            2'h1: accel_sec = 8'h1e;
            2'h2: accel_sec = 8'h3c;
            2'h3: accel_sec = 8'h78;
        endcase
    endfunction

    function automatic logic [7:0] power_watts(input logic [1:0] idx);
        power_watts = {4'h0, idx, 2'h0} + {5'h00, idx, 1'h0} + 8'h05
                      - {6'h00, idx};
    endfunction

endpackage

// *** design/spc_top.sv ***
// Functional notes
// R1 - Power key press toggles running and off; display dark when off.
// R2 - Running display shows present speed with no letter.
// R3 - Display stays unlit throughout the off state.
// R4 - Settings and run state are saved and restored after power loss.
// R5 - Speed ramps up after switch-on; right dot lit during ramp.
// R6 - Minus and plus step speed by ten within seventy to two thousand.
// R7 - Held minus or plus repeats the step at increasing rate.
// R8 - Running, minus held plus two power presses sets seventy rpm.
// R9 - Running, plus held plus two power presses sets two thousand rpm.
// R10 - Mode presses step through power, interval, acceleration views.
// R11 - Power takes four levels 5, 10, 15, 20 W, adjacent steps.
// R12 - Five seconds after last shown, display returns to speed.
// R13 - Another mode press ends the current adjustment at once.
// R14 - Interval 0 to 240 s in steps of two; zero disables it.
// R15 - Non-zero interval restarts the stirring cycle after each interval.
// R16 - Interval shows 6 s shortest active and 240 s longest.
// R17 - Acceleration selects 20, 30, 60 or 120 s with minus and plus.
// R18 - Acceleration time spans switch-on to full speed, sets ramp rate.
// R19 - Bar loss during ramp stops motor, drops setpoint 100, restarts.
// R20 - Stop, reduce, restart repeats until ramp completes.
// R21 - Decoupling monitor is always active, no way to disable.
// R22 - Minus and plus saturate at each setting's limits.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module spc_top
    import spc_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Operator keys
    input wire logic key_power,
    input wire logic key_mode,
    input wire logic key_minus,
    input wire logic key_plus,
    // Display
    output logic disp_on,
    output logic [1:0] disp_letter,
    output logic [11:0] disp_value,
    output logic disp_dot,
    // Motor drive
    input wire logic bar_lost,
    output logic motor_run,
    output logic [11:0] motor_setpoint,
    output logic [7:0] motor_power_w,
    // Setting retention store
    input wire logic nv_valid,
    input wire logic [NV_W-1:0] nv_data_in,
    output logic nv_save,
    output logic [NV_W-1:0] nv_data_out,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata
);

    // ************************************************************
    // Time base
    // ************************************************************
    logic [15:0] div_r;
    logic tick_ms;

    always_ff @(posedge mclk) begin
        if (rst) begin
            div_r <= 16'h0000;
            tick_ms <= 1'b0;
        end else if (div_r == 16'(TICK_CYCLES_P - 1)) begin
            div_r <= 16'h0000;
            tick_ms <= 1'b1;
        end else begin
            div_r <= div_r + 16'h0001;
            tick_ms <= 1'b0;
        end
    end

    // ************************************************************
    // Keys
    // ************************************************************
    logic pwr_press, mode_press, minus_step, plus_step;
    logic minus_held, plus_held;

    spc_key #(.REPEAT(1'b0)) u_key_power (
        .mclk(mclk), .rst(rst), .tick_ms(tick_ms), .key(key_power),
        .press(pwr_press), .step(), .held()
    );
    spc_key #(.REPEAT(1'b0)) u_key_mode (
        .mclk(mclk), .rst(rst), .tick_ms(tick_ms), .key(key_mode),
        .press(mode_press), .step(), .held()
    );
    spc_key #(.REPEAT(1'b1)) u_key_minus (
        .mclk(mclk), .rst(rst), .tick_ms(tick_ms), .key(key_minus),
        .press(), .step(minus_step), .held(minus_held)
    ); // R7
    spc_key #(.REPEAT(1'b1)) u_key_plus (
        .mclk(mclk), .rst(rst), .tick_ms(tick_ms), .key(key_plus),
        .press(), .step(plus_step), .held(plus_held)
    ); // R7

    // ************************************************************
    // Control state
    // ************************************************************
    spc_state_type state_r;
    spc_view_type view_r;
    logic boot_r;
    logic [11:0] speed_r;
    logic [1:0] power_r;
    logic [1:0] accel_r;
    logic [7:0] intv_r;
    logic [11:0] ramp_r;
    logic [16:0] acc_r;
    logic [12:0] halt_r;
    logic [17:0] intv_cnt_r;
    logic [12:0] view_cnt_r;
    logic [12:0] qs_cnt_r;
    logic qs_armed_r;
    logic [7:0] retry_r;
    logic running, qs_ctx, toggle, qs_fire, restore, lost, intv_end;
    logic adj_speed, adj_other;
    logic [16:0] accel_ms;
    logic [NV_W-1:0] nv_pack;

    assign running = state_r != ST_OFF;
    assign restore = boot_r & nv_valid;
    assign qs_ctx = running & (minus_held | plus_held);
    assign toggle = pwr_press & ~qs_ctx; // R1
    assign qs_fire = qs_ctx & pwr_press & qs_armed_r;
    assign lost = state_r == ST_RAMP && bar_lost; // R21
    assign accel_ms = 17'(accel_sec(accel_r)) * 17'(MS_PER_S);
    assign intv_end = intv_r != 8'h00
                      && intv_cnt_r >= 18'(intv_r) * 18'(MS_PER_S); // R15
    assign adj_speed = running && view_r == V_SPEED;
    assign adj_other = running && view_r != V_SPEED;

    always_ff @(posedge mclk) begin
        if (rst) begin
            boot_r <= 1'b1;
        end else begin
            boot_r <= 1'b0;
        end
    end

    // ************************************************************
    // Run state machine
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= ST_OFF;
            halt_r <= 13'h0000;
        end else if (restore) begin
            state_r <= nv_data_in[NV_RUN_BIT] ? ST_RAMP : ST_OFF; // R4
        end else if (toggle) begin
            state_r <= running ? ST_OFF : ST_RAMP; // R1
        end else begin
            unique case (state_r)
                ST_OFF: begin
                    halt_r <= 13'h0000;
                end
                ST_HALT: begin
                    if (tick_ms) begin
                        if (halt_r >= HALT_MS) begin
                            state_r <= ST_RAMP; // R20
                        end else begin
                            halt_r <= halt_r + 13'h0001;
                        end
                    end
                end
                ST_RAMP: begin
                    if (lost || intv_end) begin
                        state_r <= ST_HALT; // R19
                        halt_r <= 13'h0000;
                    end else if (ramp_r >= speed_r) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (intv_end) begin
                        state_r <= ST_HALT; // R15
                        halt_r <= 13'h0000;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Ramp generator
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            ramp_r <= 12'h000;
            acc_r <= 17'h00000;
        end else if (state_r == ST_RAMP) begin
            if (ramp_r >= speed_r) begin
                ramp_r <= speed_r;
            end else if (tick_ms) begin
                if (acc_r + 17'(SPEED_MAX) >= accel_ms) begin
                    acc_r <= acc_r + 17'(SPEED_MAX) - accel_ms; // R18
                    ramp_r <= ramp_r + 12'h001; // R5
                end else begin
                    acc_r <= acc_r + 17'(SPEED_MAX);
                end
            end
        end else if (state_r == ST_RUN) begin
            ramp_r <= speed_r;
        end else begin
            ramp_r <= 12'h000;
            acc_r <= 17'h00000;
        end
    end

    // ************************************************************
    // Interval timer
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            intv_cnt_r <= 18'h00000;
        end else if (state_r == ST_RAMP || state_r == ST_RUN) begin
            if (intv_end) begin
                intv_cnt_r <= 18'h00000;
            end else if (tick_ms) begin
                intv_cnt_r <= intv_cnt_r + 18'h00001;
            end
        end else begin
            intv_cnt_r <= 18'h00000;
        end
    end

    // ************************************************************
    // Quick set
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            qs_armed_r <= 1'b0;
            qs_cnt_r <= 13'h0000;
        end else if (!qs_ctx || qs_fire) begin
            qs_armed_r <= 1'b0;
        end else if (pwr_press) begin
            qs_armed_r <= 1'b1;
            qs_cnt_r <= QS_WINDOW_MS;
        end else if (tick_ms && qs_armed_r) begin
            if (qs_cnt_r == 13'h0000) begin
                qs_armed_r <= 1'b0;
            end else begin
                qs_cnt_r <= qs_cnt_r - 13'h0001;
            end
        end
    end

    // ************************************************************
    // Speed setpoint
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            speed_r <= SPEED_RST;
            retry_r <= 8'h00;
        end else if (restore) begin
            speed_r <= nv_data_in[NV_SPEED_LSB +: 12]; // R4
        end else if (lost) begin
            retry_r <= retry_r + 8'h01;
            if (speed_r >= SPEED_MIN + SPEED_DROP) begin
                speed_r <= speed_r - SPEED_DROP; // R19
            end else begin
                speed_r <= SPEED_MIN;
            end
        end else if (reg_wr && reg_addr == REG_SPEED) begin
            if (reg_wdata[11:0] < SPEED_MIN) begin
                speed_r <= SPEED_MIN;
            end else if (reg_wdata[11:0] > SPEED_MAX) begin
                speed_r <= SPEED_MAX;
            end else begin
                speed_r <= reg_wdata[11:0];
            end
        end else if (qs_fire) begin
            speed_r <= minus_held ? SPEED_MIN : SPEED_MAX; // R8 R9
        end else if (adj_speed && minus_step) begin
            if (speed_r >= SPEED_MIN + SPEED_STEP) begin
                speed_r <= speed_r - SPEED_STEP; // R6
            end else begin
                speed_r <= SPEED_MIN; // R22
            end
        end else if (adj_speed && plus_step) begin
            if (speed_r + SPEED_STEP <= SPEED_MAX) begin
                speed_r <= speed_r + SPEED_STEP; // R6
            end else begin
                speed_r <= SPEED_MAX; // R22
            end
        end
    end

    // ************************************************************
    // Power, interval and acceleration settings
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            power_r <= POWER_RST;
            accel_r <= ACCEL_RST;
            intv_r <= INTV_RST;
        end else if (restore) begin
            power_r <= nv_data_in[NV_POWER_LSB +: 2];
            accel_r <= nv_data_in[NV_ACCEL_LSB +: 2];
            intv_r <= nv_data_in[NV_INTV_LSB +: 8];
        end else if (adj_other && (minus_step || plus_step)) begin
            unique case (view_r)
                V_POWER: begin
                    if (minus_step && power_r != 2'h0) begin
                        power_r <= power_r - 2'h1; // R11
                    end else if (plus_step && power_r != 2'h3) begin
                        power_r <= power_r + 2'h1; // R11
                    end
                end
                V_ACCEL: begin
                    if (minus_step && accel_r != 2'h0) begin
                        accel_r <= accel_r - 2'h1; // R17
                    end else if (plus_step && accel_r != 2'h3) begin
                        accel_r <= accel_r + 2'h1; // R17
                    end
                end
                V_INTERVAL: begin
                    if (minus_step) begin
                        if (intv_r <= INTV_MIN_ON) begin
                            intv_r <= 8'h00; // R14
                        end else begin
                            intv_r <= intv_r - INTV_STEP; // R14
                        end
                    end else if (intv_r == 8'h00) begin
                        intv_r <= INTV_MIN_ON; // R16
                    end else if (intv_r < INTV_MAX) begin
                        intv_r <= intv_r + INTV_STEP; // R14
                    end
                end
                V_SPEED: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Display view selection
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            view_r <= V_SPEED;
            view_cnt_r <= 13'h0000;
        end else if (!running) begin
            view_r <= V_SPEED;
        end else if (mode_press) begin
            view_cnt_r <= 13'h0000;
            unique case (view_r)
                V_SPEED: view_r <= V_POWER; // R10
                V_POWER: view_r <= V_INTERVAL; // R10 R13
                V_INTERVAL: view_r <= V_ACCEL; // R10 R13
                V_ACCEL: view_r <= V_SPEED; // R13
            endcase
        end else if (adj_other && (minus_step || plus_step)) begin
            view_cnt_r <= 13'h0000;
        end else if (adj_other && tick_ms) begin
            if (view_cnt_r >= DISP_TIMEOUT_MS - 13'h0001) begin
                view_r <= V_SPEED; // R12
            end else begin
                view_cnt_r <= view_cnt_r + 13'h0001;
            end
        end
    end

    // ************************************************************
    // Display and motor outputs
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            disp_on <= 1'b0;
            disp_letter <= 2'h0;
            disp_value <= 12'h000;
            disp_dot <= 1'b0;
            motor_run <= 1'b0;
            motor_setpoint <= 12'h000;
            motor_power_w <= 8'h00;
        end else begin
            disp_on <= running; // R3
            disp_letter <= view_r; // R2
            disp_dot <= state_r == ST_RAMP; // R5
            motor_run <= state_r == ST_RAMP || state_r == ST_RUN;
            motor_setpoint <= ramp_r;
            motor_power_w <= power_watts(power_r);
            unique case (view_r)
                V_SPEED: disp_value <= speed_r; // R2
                V_POWER: disp_value <= {4'h0, power_watts(power_r)};
                V_INTERVAL: disp_value <= {4'h0, intv_r}; // R16
                V_ACCEL: disp_value <= {4'h0, accel_sec(accel_r)};
            endcase
        end
    end

    // ************************************************************
    // Setting retention
    // ************************************************************
    assign nv_pack = {running, intv_r, accel_r, power_r, speed_r};

    always_ff @(posedge mclk) begin
        if (rst) begin
            nv_save <= 1'b0;
            nv_data_out <= {NV_W{1'b0}};
        end else if (boot_r) begin
            nv_save <= 1'b0;
            nv_data_out <= nv_valid ? nv_data_in : nv_data_out;
        end else begin
            nv_save <= nv_pack != nv_data_out; // R4
            nv_data_out <= nv_pack;
        end
    end

    // ************************************************************
    // Register port
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_STATUS: reg_rdata <= {retry_r, 4'h0, view_r,
                                          state_r == ST_RAMP, running};
                REG_SPEED: reg_rdata <= {4'h0, speed_r};
                REG_RAMP: reg_rdata <= {4'h0, ramp_r};
                REG_SETTINGS: reg_rdata <= {intv_r, 4'h0, accel_r, power_r};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule
